// ### core/upsc_pkg.sv
//
// Contract
// - activity pending flag shows module busy; the code sets it only while the sleep guard bit is set
// - suspend gates clock, hardware may clear
// - last endpoint number recorded per transfer
// - direction bit one transmit zero receive
// - odd bank indicator for last transfer
// - live single ended zero flag
// - packet halt set on setup token in device mode
// - host enable drives both pull downs
// - attach enable drives plus pull up in device mode
// - resume bit drives resume signalling
// - writing one clears pingpong pointers
// - live j state flag in host mode
// - token busy while token executes
// - reset bit drives bus reset in host
// - frame marker sent every millisecond
// - slow rate bit reads zero in device
// - seven bit device address stored
// - token type codes setup in out
// - only low byte implemented, rest zero
package upsc_pkg;
  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [7:0] OFS_PWRC = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0C;
  localparam logic [7:0] OFS_TOKN = 8'h10;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int B_ACTPND = 7;
  localparam int B_SLPGRD = 4;
  localparam int B_SUSP   = 1;
  localparam int B_PWR    = 0;
  localparam int B_JST    = 7;
  localparam int B_SE0    = 6;
  localparam int B_PKTH   = 5;
  localparam int B_BRST   = 4;
  localparam int B_HOST   = 3;
  localparam int B_RESUME = 2;
  localparam int B_PPCLR  = 1;
  localparam int B_ATTSOF = 0;
  localparam int B_SLOW   = 7;
  // ----------------------------------------
  // token codes and timing
  // ----------------------------------------
  localparam logic [3:0] PID_SETUP = 4'hD;
  localparam logic [3:0] PID_IN    = 4'h9;
  localparam logic [3:0] PID_OUT   = 4'h1;
  localparam int CLK_MHZ    = 100;
  localparam int SOF_US     = 1000;
  localparam int SOF_CYCLES = SOF_US * CLK_MHZ;
  localparam logic [7:0] RST_BYTE = 8'h00;
endpackage : upsc_pkg

// ### core/upsc_top.sv
`timescale 1ns/100ps
`default_nettype none
module upsc_top
  import upsc_pkg::*;
#(
  parameter int SOF_PERIOD = SOF_CYCLES
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // engine events
  input  wire logic        XFER_DONE,
  input  wire logic [3:0]  XFER_EP,
  input  wire logic        XFER_TX,
  input  wire logic        XFER_ODD,
  input  wire logic        SETUP_SEEN,
  input  wire logic        ACTIVITY,
  input  wire logic        TOKEN_DONE,
  input  wire logic        WAKE_EVENT,
  // line pins
  input  wire logic        LINE_DP,
  input  wire logic        LINE_DM,
  // control outputs
  output logic             CLK_GATE,
  output logic             XCVR_LOWPWR,
  output logic             MODULE_ON,
  output logic             PKT_HALT,
  output logic             DP_PULLUP,
  output logic             DP_PULLDN,
  output logic             DM_PULLDN,
  output logic             RESUME_DRIVE,
  output logic             BUS_RESET,
  output logic             PP_CLEAR,
  output logic             SOF_PULSE,
  output logic             TOKEN_START,
  output logic [7:0]       TOKEN_CMD,
  output logic [6:0]       DEV_ADDR,
  output logic             SLOW_RATE
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] dp_s, dm_s;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dp_s <= 2'h3;
      dm_s <= 2'h0;
    end else begin
      dp_s <= {dp_s[0], LINE_DP};
      dm_s <= {dm_s[0], LINE_DM};
    end
  end
  logic se0, jst;
  logic slow;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      se0 <= 1'b0;
      jst <= 1'b0;
    end else begin
      se0 <= !dp_s[1] && !dm_s[1];
      jst <= slow ? (!dp_s[1] && dm_s[1]) : (dp_s[1] && !dm_s[1]);
    end
  end
  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic       actpnd, slpgrd, susp, pwr;
  logic [3:0] ep;
  logic       dir, odd;
  logic       pkth, host, resume, brst, attsof, token_in_progress;
  logic [6:0] addr;
  logic [7:0] tok;
  logic       wr, rd;
  assign wr = PSEL && PENABLE && PWRITE && PSTRB[0];
  assign rd = PSEL && PENABLE && !PWRITE;
  logic [7:0] wb;
  assign wb = PWDATA[7:0];
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      slpgrd <= 1'b0;
      pwr    <= 1'b0;
    end else if (wr && PADDR == OFS_PWRC) begin
      slpgrd <= wb[B_SLPGRD];
      pwr    <= wb[B_PWR];
    end
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      actpnd <= 1'b0;
    end else if (ACTIVITY && slpgrd) begin
      actpnd <= 1'b1;
    end else if (!slpgrd || !ACTIVITY) begin
      actpnd <= 1'b0;
    end
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      susp <= 1'b0;
    end else if (WAKE_EVENT) begin
      susp <= 1'b0;
    end else if (wr && PADDR == OFS_PWRC) begin
      susp <= wb[B_SUSP];
    end
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ep  <= 4'h0;
      dir <= 1'b0;
      odd <= 1'b0;
    end else if (XFER_DONE) begin
      ep  <= XFER_EP;
      dir <= XFER_TX;
      odd <= XFER_ODD;
    end
  end
  logic ctl_wr;
  assign ctl_wr = wr && PADDR == OFS_CTRL;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pkth <= 1'b0;
    end else if (SETUP_SEEN && !host) begin
      pkth <= 1'b1;
    end else if (ctl_wr && !host) begin
      pkth <= wb[B_PKTH];
    end
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      host   <= 1'b0;
      resume <= 1'b0;
      attsof <= 1'b0;
      brst   <= 1'b0;
    end else if (ctl_wr) begin
      host   <= wb[B_HOST];
      resume <= wb[B_RESUME];
      attsof <= wb[B_ATTSOF];
      brst   <= host ? wb[B_BRST] : 1'b0;
    end
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      addr <= 7'h00;
      slow <= 1'b0;
    end else if (wr && PADDR == OFS_ADDR) begin
      addr <= wb[6:0];
      slow <= host && wb[B_SLOW];
    end else if (!host) begin
      slow <= 1'b0;
    end
  end
  logic tok_wr;
  assign tok_wr = wr && PADDR == OFS_TOKN;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tok     <= RST_BYTE;
      token_in_progress <= 1'b0;
    end else begin
      if (tok_wr) begin
        tok <= wb;
      end
      if (tok_wr && host) begin
        token_in_progress <= 1'b1;
      end else if (TOKEN_DONE || !host) begin
        token_in_progress <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // frame marker timer
  // ----------------------------------------
  logic [31:0] sof_cnt;
  logic        sof_tick;
  assign sof_tick = sof_cnt == 32'(SOF_PERIOD - 1);
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sof_cnt <= 32'h0000_0000;
    end else if (!(host && attsof) || sof_tick) begin
      sof_cnt <= 32'h0000_0000;
    end else begin
      sof_cnt <= sof_cnt + 32'h0000_0001;
    end
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CLK_GATE     <= 1'b0;
      XCVR_LOWPWR  <= 1'b0;
      MODULE_ON    <= 1'b0;
      PKT_HALT     <= 1'b0;
      DP_PULLUP    <= 1'b0;
      DP_PULLDN    <= 1'b0;
      DM_PULLDN    <= 1'b0;
      RESUME_DRIVE <= 1'b0;
      BUS_RESET    <= 1'b0;
      PP_CLEAR     <= 1'b0;
      SOF_PULSE    <= 1'b0;
      TOKEN_START  <= 1'b0;
      TOKEN_CMD    <= RST_BYTE;
      DEV_ADDR     <= 7'h00;
      SLOW_RATE    <= 1'b0;
    end else begin
      CLK_GATE     <= susp;
      XCVR_LOWPWR  <= susp;
      MODULE_ON    <= pwr;
      PKT_HALT     <= pkth && !host;
      DP_PULLUP    <= attsof && !host;
      DP_PULLDN    <= host;
      DM_PULLDN    <= host;
      RESUME_DRIVE <= resume;
      BUS_RESET    <= brst && host;
      PP_CLEAR     <= ctl_wr && wb[B_PPCLR];
      SOF_PULSE    <= sof_tick && host && attsof;
      TOKEN_START  <= tok_wr && host;
      TOKEN_CMD    <= tok_wr ? wb : tok;
      DEV_ADDR     <= addr;
      SLOW_RATE    <= slow;
    end
  end
  // ----------------------------------------
  // apb read path
  // ----------------------------------------
  logic [7:0] ctl_view;
  assign ctl_view = host ?
    {jst, se0, token_in_progress, brst, host, resume, 1'b0, attsof} :
    {1'b0, se0, pkth, 1'b0, host, resume, 1'b0, attsof};
  logic [7:0] rbyte;
  logic       bad;
  always_comb begin
    rbyte = 8'h00;
    bad   = 1'b0;
    unique case (PADDR)
      OFS_PWRC: rbyte = {actpnd, 2'b00, slpgrd, 2'b00, susp, pwr};
      OFS_STAT: rbyte = {ep, dir, odd, 2'b00};
      OFS_CTRL: rbyte = ctl_view;
      OFS_ADDR: rbyte = {slow && host, addr};
      OFS_TOKN: rbyte = tok;
      default:  bad = 1'b1;
    endcase
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && bad;
      PRDATA  <= {24'h00_0000, rbyte};
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_pulldn;
    @(posedge CLK) disable iff (!RST_N) host |=> DP_PULLDN && DM_PULLDN;
  endproperty
  a_pulldn: assert property (p_pulldn) else $error("pull downs missing");
  property p_pullup;
    @(posedge CLK) disable iff (!RST_N) DP_PULLUP |-> !DP_PULLDN;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull up with host");
  property p_setup;
    @(posedge CLK) disable iff (!RST_N) SETUP_SEEN && !host |=> pkth ##1 PKT_HALT || host;
  endproperty
  a_setup: assert property (p_setup) else $error("setup did not halt");
  property p_stat;
    @(posedge CLK) disable iff (!RST_N) XFER_DONE |=> ep == $past(XFER_EP) && dir == $past(XFER_TX);
  endproperty
  a_stat: assert property (p_stat) else $error("status not captured");
  property p_upper;
    @(posedge CLK) disable iff (!RST_N) PRDATA[31:8] == 24'h00_0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_slow;
    @(posedge CLK) disable iff (!RST_N) !host |=> !SLOW_RATE || $past(host) == 1'b0 && !slow;
  endproperty
  a_slow: assert property (p_slow) else $error("slow rate in device");
  property p_sof;
    @(posedge CLK) disable iff (!RST_N) SOF_PULSE |-> ##1 !SOF_PULSE;
  endproperty
  a_sof: assert property (p_sof) else $error("frame pulse too long");
  property p_susp;
    @(posedge CLK) disable iff (!RST_N) WAKE_EVENT |=> !susp ##1 !CLK_GATE;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend not cleared");
  property p_rst;
    @(posedge CLK) disable iff (!RST_N) BUS_RESET |-> $past(host);
  endproperty
  a_rst: assert property (p_rst) else $error("bus reset in device");
  // ----------------------------------------
  // register and flag checks
  // ----------------------------------------
  property p_actpnd;
    @(posedge CLK) disable iff (!RST_N) ACTIVITY && slpgrd |=> actpnd;
  endproperty
  a_actpnd: assert property (p_actpnd) else $error("activity pending not set");
  property p_noguard;
    @(posedge CLK) disable iff (!RST_N) !slpgrd |=> !actpnd;
  endproperty
  a_noguard: assert property (p_noguard) else $error("activity pending without guard");
  property p_dir;
    @(posedge CLK) disable iff (!RST_N) XFER_DONE |=> dir == $past(XFER_TX);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not captured");
  property p_odd;
    @(posedge CLK) disable iff (!RST_N) XFER_DONE |=> odd == $past(XFER_ODD);
  endproperty
  a_odd: assert property (p_odd) else $error("bank not captured");
  property p_hold;
    @(posedge CLK) disable iff (!RST_N)
      !XFER_DONE |=> $stable(ep) && $stable(dir) && $stable(odd);
  endproperty
  a_hold: assert property (p_hold) else $error("status changed without transfer");
  property p_se0;
    @(posedge CLK) disable iff (!RST_N) !dp_s[1] && !dm_s[1] |=> se0;
  endproperty
  a_se0: assert property (p_se0) else $error("single ended zero missed");
  property p_jst;
    @(posedge CLK) disable iff (!RST_N)
      (slow && !dp_s[1] && dm_s[1]) || (!slow && dp_s[1] && !dm_s[1]) |=> jst;
  endproperty
  a_jst: assert property (p_jst) else $error("j state missed");
  property p_ppclr;
    @(posedge CLK) disable iff (!RST_N) ctl_wr && wb[B_PPCLR] |=> PP_CLEAR;
  endproperty
  a_ppclr: assert property (p_ppclr) else $error("pingpong clear missing");
  property p_token_in_progress;
    @(posedge CLK) disable iff (!RST_N) tok_wr && host |=> token_in_progress;
  endproperty
  a_token_in_progress: assert property (p_token_in_progress) else $error("token busy not set");
  property p_tokdone;
    @(posedge CLK) disable iff (!RST_N) TOKEN_DONE && !(tok_wr && host) |=> !token_in_progress;
  endproperty
  a_tokdone: assert property (p_tokdone) else $error("token busy stuck");
  property p_tokstart;
    @(posedge CLK) disable iff (!RST_N) TOKEN_START |-> $past(tok_wr) && $past(host);
  endproperty
  a_tokstart: assert property (p_tokstart) else $error("token start unprompted");
  property p_addr;
    @(posedge CLK) disable iff (!RST_N) wr && PADDR == OFS_ADDR |=> addr == $past(wb[6:0]);
  endproperty
  a_addr: assert property (p_addr) else $error("address not stored");
  property p_view;
    @(posedge CLK) disable iff (!RST_N)
      PSEL && !PENABLE && PADDR == OFS_CTRL && !host |=> (PRDATA[7:0] & 8'h92) == 8'h00;
  endproperty
  a_view: assert property (p_view) else $error("device view shows host bits");
  property p_bad;
    @(posedge CLK) disable iff (!RST_N)
      PSEL && !PENABLE && bad |=> PSLVERR && PRDATA == 32'h0000_0000;
  endproperty
  a_bad: assert property (p_bad) else $error("unmapped read not refused");
  property p_suspwr;
    @(posedge CLK) disable iff (!RST_N)
      wr && PADDR == OFS_PWRC && wb[B_SUSP] && !WAKE_EVENT |=> susp ##1 CLK_GATE && XCVR_LOWPWR;
  endproperty
  a_suspwr: assert property (p_suspwr) else $error("suspend not applied");
  property p_sofoff;
    @(posedge CLK) disable iff (!RST_N) !(host && attsof) |=> !SOF_PULSE;
  endproperty
  a_sofoff: assert property (p_sofoff) else $error("frame pulse while disabled");
  c_sof: cover property (@(posedge CLK) SOF_PULSE);
  c_tok: cover property (@(posedge CLK) TOKEN_START);
  c_halt: cover property (@(posedge CLK) PKT_HALT);
  c_wake: cover property (@(posedge CLK) WAKE_EVENT && susp);
  c_brst: cover property (@(posedge CLK) BUS_RESET);
endmodule : upsc_top
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import upsc_pkg::*;
  logic CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, LINE_DP, LINE_DM;
  logic XFER_DONE, XFER_TX, XFER_ODD, SETUP_SEEN, TOKEN_DONE, WAKE_EVENT, ACTIVITY;
  logic CLK_GATE, XCVR_LOWPWR, MODULE_ON, PKT_HALT, DP_PULLUP, DP_PULLDN, DM_PULLDN;
  logic RESUME_DRIVE, BUS_RESET, PP_CLEAR, SOF_PULSE, TOKEN_START, SLOW_RATE;
  logic [7:0]  PADDR, TOKEN_CMD;
  logic [31:0] PWDATA, PRDATA, r;
  logic [3:0]  PSTRB, XFER_EP;
  logic [6:0]  DEV_ADDR;
  logic [9:0]  q[$];
  logic [9:0]  e;
  logic [3:0]  pids [3];
  int          pc [3];
  int          error_cnt, total_checks;
  upsc_top #(.SOF_PERIOD(20)) dut_u (
    .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .XFER_DONE(XFER_DONE), .XFER_EP(XFER_EP), .XFER_TX(XFER_TX),
    .XFER_ODD(XFER_ODD), .SETUP_SEEN(SETUP_SEEN), .ACTIVITY(ACTIVITY),
    .TOKEN_DONE(TOKEN_DONE), .WAKE_EVENT(WAKE_EVENT), .LINE_DP(LINE_DP), .LINE_DM(LINE_DM),
    .CLK_GATE(CLK_GATE), .XCVR_LOWPWR(XCVR_LOWPWR), .MODULE_ON(MODULE_ON),
    .PKT_HALT(PKT_HALT), .DP_PULLUP(DP_PULLUP), .DP_PULLDN(DP_PULLDN), .DM_PULLDN(DM_PULLDN),
    .RESUME_DRIVE(RESUME_DRIVE), .BUS_RESET(BUS_RESET), .PP_CLEAR(PP_CLEAR),
    .SOF_PULSE(SOF_PULSE), .TOKEN_START(TOKEN_START), .TOKEN_CMD(TOKEN_CMD),
    .DEV_ADDR(DEV_ADDR), .SLOW_RATE(SLOW_RATE)
  );
  upsc_peer peer_u (
    .CLK(CLK), .LINE_DP(LINE_DP), .LINE_DM(LINE_DM), .XFER_DONE(XFER_DONE),
    .XFER_EP(XFER_EP), .XFER_TX(XFER_TX), .XFER_ODD(XFER_ODD), .SETUP_SEEN(SETUP_SEEN),
    .TOKEN_DONE(TOKEN_DONE), .WAKE_EVENT(WAKE_EVENT), .ACTIVITY(ACTIVITY)
  );
  initial begin
    CLK = 0;
    forever #5 CLK = ~CLK;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask : cmp
  task automatic w(input int n);
    repeat (n) @(posedge CLK);
  endtask : w
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [7:0] x);
    q.push_back({wr, a > OFS_TOKN, x});
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, wr, a, d};
    @(posedge CLK);
    PENABLE <= 1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    {PSEL, PENABLE} <= 2'b00;
    @(posedge CLK);
  endtask : apb
  task automatic results;
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // ----------------------------------------
  // scoreboard and pulse counters
  // ----------------------------------------
  always @(posedge CLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1) begin
      e = q.pop_front();
      cmp("pslverr", e[8], PSLVERR);
      if (!e[9]) cmp("prdata", {24'h0, e[7:0]}, PRDATA);
    end
  end
  always @(negedge CLK) begin
    if (PP_CLEAR) pc[0]++;
    if (SOF_PULSE) pc[1]++;
    if (TOKEN_START) pc[2]++;
  end
  initial begin
    #50us;
    error_cnt++;
    results();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, RST_N} = '0;
    PSTRB = 4'hF;
    pids = '{PID_SETUP, PID_IN, PID_OUT};
    void'($urandom(32'h69d5_18e0));
    w(4);
    RST_N <= 1;
    for (int a = 0; a < 24; a += 4) apb(0, a[7:0], 0, 0);
    cmp("outs", {CLK_GATE, MODULE_ON, DP_PULLUP, DP_PULLDN, BUS_RESET}, 0);
    apb(1, OFS_PWRC, 32'hFFFF_FFFF, 0);
    apb(0, OFS_PWRC, 0, 8'h13);
    cmp("pwr", {CLK_GATE, XCVR_LOWPWR, MODULE_ON}, 3'b111);
    peer_u.pulse(2);
    w(2);
    apb(0, OFS_PWRC, 0, 8'h11);
    peer_u.act(1'b1);
    w(3);
    apb(0, OFS_PWRC, 0, 8'h91);
    apb(1, OFS_CTRL, 32'h13, 0);
    w(2);
    cmp("dev", {DP_PULLUP, DP_PULLDN, DM_PULLDN, BUS_RESET}, 4'b1000);
    cmp("ppclr", pc[0], 1);
    peer_u.pulse(0);
    w(2);
    cmp("halt", PKT_HALT, 1);
    peer_u.line(0, 0);
    w(5);
    apb(0, OFS_CTRL, 0, 8'h61);
    r = $urandom;
    apb(1, OFS_ADDR, r, 0);
    apb(0, OFS_ADDR, 0, {1'b0, r[6:0]});
    cmp("addr", DEV_ADDR, r[6:0]);
    PSTRB <= 4'hE;
    apb(1, OFS_ADDR, ~r, 0);
    PSTRB <= 4'hF;
    apb(0, OFS_ADDR, 0, {1'b0, r[6:0]});
    apb(1, OFS_CTRL, 32'h0D, 0);
    apb(1, OFS_CTRL, 32'h1D, 0);
    apb(1, OFS_ADDR, r, 0);
    peer_u.line(~r[7], r[7]);
    apb(0, OFS_ADDR, 0, r[7:0]);
    cmp("slow", SLOW_RATE, r[7]);
    cmp("host", {DP_PULLUP, DP_PULLDN, DM_PULLDN, BUS_RESET, RESUME_DRIVE}, 5'h0F);
    pc[1] = 0;
    w(100);
    cmp("sof", pc[1], 5);
    apb(0, OFS_CTRL, 0, 8'h9D);
    for (int i = 0; i < 3; i++) begin
      r = $urandom;
      apb(1, OFS_TOKN, {pids[i], r[3:0]}, 0);
      apb(0, OFS_CTRL, 0, 8'hBD);
      cmp("tok", TOKEN_CMD, {pids[i], r[3:0]});
      peer_u.pulse(1);
      w(2);
      apb(0, OFS_CTRL, 0, 8'h9D);
    end
    cmp("tokstart", pc[2], 3);
    repeat (3) begin
      r = $urandom;
      peer_u.xfer(r[3:0], r[4], r[5]);
      w(2);
      apb(0, OFS_STAT, 0, {r[3:0], r[4], r[5], 2'b00});
    end
    apb(1, OFS_CTRL, 32'h08, 0);
    w(2);
    pc[1] = 0;
    w(60);
    cmp("sofoff", pc[1], 0);
    apb(1, OFS_CTRL, 0, 0);
    apb(1, OFS_PWRC, 0, 0);
    w(2);
    cmp("off", {MODULE_ON, DP_PULLDN}, 0);
    results();
  end
endmodule : tb
`default_nettype wire

// ### tb/upsc_peer.sv
`timescale 1ns/100ps
`default_nettype none
module upsc_peer (
  // bus side
  input  wire logic       CLK,
  output logic            LINE_DP,
  output logic            LINE_DM,
  // engine events
  output logic            XFER_DONE,
  output logic [3:0]      XFER_EP,
  output logic            XFER_TX,
  output logic            XFER_ODD,
  output logic            SETUP_SEEN,
  output logic            TOKEN_DONE,
  output logic            WAKE_EVENT,
  output logic            ACTIVITY
);
  logic [2:0] ev;
  assign {WAKE_EVENT, TOKEN_DONE, SETUP_SEEN} = ev;
  initial begin
    {LINE_DP, LINE_DM} = 2'b10;
    {XFER_DONE, XFER_EP, XFER_TX, XFER_ODD, ACTIVITY} = '0;
    ev = '0;
  end
  // ----------------------------------------
  // line state, idle is full-speed j
  // ----------------------------------------
  task automatic line(input logic dp, input logic dm);
    @(posedge CLK);
    LINE_DP <= dp;
    LINE_DM <= dm;
  endtask : line
  // ----------------------------------------
  // transfer report, fields scrambled after
  // ----------------------------------------
  task automatic xfer(input logic [3:0] ep, input logic tx, input logic odd);
    @(posedge CLK);
    {XFER_EP, XFER_TX, XFER_ODD, XFER_DONE} <= {ep, tx, odd, 1'b1};
    @(posedge CLK);
    {XFER_EP, XFER_TX, XFER_ODD, XFER_DONE} <= {~ep, ~tx, ~odd, 1'b0};
  endtask : xfer
  task automatic act(input logic v);
    @(posedge CLK);
    ACTIVITY <= v;
  endtask : act
  // 0 setup, 1 token done, 2 wake
  task automatic pulse(input int k);
    @(posedge CLK);
    ev <= 3'b001 << k;
    @(posedge CLK);
    ev <= '0;
  endtask : pulse
endmodule : upsc_peer
`default_nettype wire
